// File: hdl/mpms_pkg.sv
/*
  constants for the multipurpose pin mode select block: register offsets,
  field positions, mode codes, reset values and the one-shot timing.
  assumes a 10 MHz system clock and a 32-bit AHB-Lite register bus.
*/
`default_nettype none
package mpms_pkg;

  // ****************************************
  // bus and register map
  // ****************************************
  localparam int          ADDR_W             = 8;
  localparam int          DATA_W             = 32;
  localparam logic [7:0]  OFF_ENV2_CONFIG    = 8'h00;
  localparam logic [7:0]  OFF_GP_OUT_LEVEL   = 8'h04;
  localparam logic [7:0]  OFF_GP_IN_LEVEL    = 8'h08;
  localparam logic [7:0]  OFF_ONESHOT        = 8'h0C;
  localparam logic [1:0]  HTRANS_NONSEQ_BIT  = 2'h2;
  localparam logic        HRESP_OKAY         = 1'b0;
  localparam logic [31:0] RESET_ENV2_CONFIG  = 32'h0000_0000;
  localparam logic [7:0]  RESET_GP_OUT_LEVEL = 8'h00;
  localparam logic [31:0] READ_ZERO          = 32'h0000_0000;

  // ****************************************
  // terminal fields
  // ****************************************
  localparam int          PIN_COUNT          = 8;
  localparam int          MODE_W             = 2;
  localparam int          SHOT_PINS          = 2;
  localparam int          POL_PIN_ZERO_BIT   = 16;
  localparam int          POL_PIN_ONE_BIT    = 17;

  // ****************************************
  // mode codes
  // ****************************************
  localparam logic [1:0]  MODE_GP_IN         = 2'h0;
  localparam logic [1:0]  MODE_GP_OUT        = 2'h1;
  localparam logic [1:0]  MODE_SIG_A         = 2'h2;
  localparam logic [1:0]  MODE_SIG_B         = 2'h3;

  // ****************************************
  // one-shot timing
  // ****************************************
  localparam int          CLK_HZ             = 10_000_000;
  localparam int          ONESHOT_MS         = 26;
  localparam int          ONESHOT_W          = 19;
  localparam int          ONESHOT_CYCLES_INT = ONESHOT_MS * (CLK_HZ / 1000);
  localparam logic [ONESHOT_W-1:0] ONESHOT_CYCLES_DFLT = ONESHOT_CYCLES_INT[ONESHOT_W-1:0];
  localparam logic [ONESHOT_W-1:0] ONESHOT_ZERO        = 19'h0_0000;
  localparam logic [ONESHOT_W-1:0] ONESHOT_ONE         = 19'h0_0001;

endpackage

`default_nettype wire

// File: hdl/mpms_top.sv
/*
  multipurpose pin mode select: eight terminals, each steered by a 2-bit
  mode field of the environment-2 configuration register, reached over an
  AHB-Lite slave port with zero wait states.
  assumes one 10 MHz clock, pins and motion flags synchronous to it, and an
  external pad that turns pin_out / pin_oe_n into the wire level.
*/
`timescale 1ns/10ps
`default_nettype none

module mpms_top
#(
  parameter logic [mpms_pkg::ONESHOT_W-1:0] ONESHOT_CYCLES = mpms_pkg::ONESHOT_CYCLES_DFLT
)
(
  input  wire logic                          hclk,
  input  wire logic                          hresetn,
  input  wire logic                          hsel,
  input  wire logic [mpms_pkg::ADDR_W-1:0]   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [mpms_pkg::DATA_W-1:0]   hwdata,
  input  wire logic                          hready,
  output logic                               hreadyout,
  output logic [mpms_pkg::DATA_W-1:0]        hrdata,
  output logic                               hresp,
  input  wire logic                          accel_phase_flag,
  input  wire logic                          decel_phase_flag,
  input  wire logic                          constant_speed_flag,
  input  wire logic                          compare_one_match,
  input  wire logic                          compare_two_match,
  input  wire logic                          compare_three_match,
  input  wire logic                          compare_four_match,
  input  wire logic                          compare_five_match,
  input  wire logic [mpms_pkg::PIN_COUNT-1:0] pin_in,
  output logic [mpms_pkg::PIN_COUNT-1:0]     pin_out,
  output logic [mpms_pkg::PIN_COUNT-1:0]     pin_oe_n
);

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic [1:0] mode_of
  (
    input logic [mpms_pkg::DATA_W-1:0] cfg,
    input int                          idx
  );
    mode_of = cfg[idx*mpms_pkg::MODE_W +: mpms_pkg::MODE_W];
  endfunction

  function automatic logic is_signal_mode
  (
    input logic [1:0] mode
  );
    is_signal_mode = (mode == mpms_pkg::MODE_SIG_A) || (mode == mpms_pkg::MODE_SIG_B);
  endfunction

  // ****************************************
  // storage
  // ****************************************
  logic [mpms_pkg::DATA_W-1:0]    env2_config_reg;
  logic [mpms_pkg::PIN_COUNT-1:0] gp_out_level_reg;
  logic [mpms_pkg::PIN_COUNT-1:0] gp_in_level_reg;
  logic                           wr_pend_reg;
  logic [mpms_pkg::ADDR_W-1:0]    wr_addr_reg;
  logic [mpms_pkg::DATA_W-1:0]    hrdata_reg;
  logic [mpms_pkg::DATA_W-1:0]    hrdata_next;
  logic                           addr_phase;
  logic                           wr_config;
  logic                           wr_gp_out;
  logic                           wr_oneshot;
  logic [mpms_pkg::PIN_COUNT-1:0] phase_sig;
  logic [mpms_pkg::SHOT_PINS-1:0] shot_active;
  logic [mpms_pkg::SHOT_PINS-1:0] shot_pol_high;
  logic [mpms_pkg::PIN_COUNT-1:0] pin_out_next;
  logic [mpms_pkg::PIN_COUNT-1:0] pin_oe_n_next;
  logic [mpms_pkg::PIN_COUNT-1:0] pin_out_reg;
  logic [mpms_pkg::PIN_COUNT-1:0] pin_oe_n_reg;

  // ****************************************
  // ahb-lite slave
  // ****************************************
  // zero wait states: every access ends in its first data phase
  assign hreadyout = 1'b1;
  assign hresp     = mpms_pkg::HRESP_OKAY;
  assign hrdata    = hrdata_reg;

  // hsize ignored: only whole aligned words are issued
  assign addr_phase = hsel && hready && (htrans[1] == mpms_pkg::HTRANS_NONSEQ_BIT[1]);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
    end
    else if (hready)
    begin
      wr_pend_reg <= addr_phase && hwrite;
      wr_addr_reg <= haddr;
    end
  end

  assign wr_config  = wr_pend_reg && (wr_addr_reg == mpms_pkg::OFF_ENV2_CONFIG);
  assign wr_gp_out  = wr_pend_reg && (wr_addr_reg == mpms_pkg::OFF_GP_OUT_LEVEL);
  assign wr_oneshot = wr_pend_reg && (wr_addr_reg == mpms_pkg::OFF_ONESHOT);

  // read data prepared in the address phase so it stands in the data phase
  always_comb
  begin
    hrdata_next = mpms_pkg::READ_ZERO;
    if (haddr == mpms_pkg::OFF_ENV2_CONFIG)
    begin
      hrdata_next = env2_config_reg;
    end
    else if (haddr == mpms_pkg::OFF_GP_OUT_LEVEL)
    begin
      hrdata_next[mpms_pkg::PIN_COUNT-1:0] = gp_out_level_reg;
    end
    else if (haddr == mpms_pkg::OFF_GP_IN_LEVEL)
    begin
      hrdata_next[mpms_pkg::PIN_COUNT-1:0] = gp_in_level_reg;
    end
    else if (haddr == mpms_pkg::OFF_ONESHOT)
    begin
      hrdata_next[mpms_pkg::SHOT_PINS-1:0] = shot_active;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata_reg <= mpms_pkg::READ_ZERO;
    end
    else if (addr_phase && !hwrite)
    begin
      hrdata_reg <= hrdata_next;
    end
  end

  // ****************************************
  // software registers
  // ****************************************
  // upper half kept for the encoder and pulser settings; only bits 16 and 17 (polarity of pins zero and one) used here
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      env2_config_reg <= mpms_pkg::RESET_ENV2_CONFIG;
    end
    else if (wr_config)
    begin
      env2_config_reg <= hwdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      gp_out_level_reg <= mpms_pkg::RESET_GP_OUT_LEVEL;
    end
    else if (wr_gp_out)
    begin
      gp_out_level_reg <= hwdata[mpms_pkg::PIN_COUNT-1:0];
    end
  end

  // pins sampled every cycle, whatever their mode
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      gp_in_level_reg <= '0;
    end
    else
    begin
      gp_in_level_reg <= pin_in;
    end
  end

  // ****************************************
  // signal sources
  // ****************************************
  assign phase_sig = {compare_five_match,
                      compare_four_match,
                      compare_three_match,
                      compare_two_match,
                      compare_one_match,
                      constant_speed_flag,
                      decel_phase_flag,
                      accel_phase_flag};

  assign shot_pol_high = {env2_config_reg[mpms_pkg::POL_PIN_ONE_BIT],
                          env2_config_reg[mpms_pkg::POL_PIN_ZERO_BIT]};

  // ****************************************
  // one-shot timers, pins zero and one
  // ****************************************
  // a trigger while running restarts the full period
  genvar s;
  generate
    for (s = 0; s < mpms_pkg::SHOT_PINS; s = s + 1)
    begin : g_shot
      logic [mpms_pkg::ONESHOT_W-1:0] count_reg;
      logic                           trigger;

      assign trigger = wr_oneshot && hwdata[s] &&
                       (mode_of(env2_config_reg, s) == mpms_pkg::MODE_SIG_B);

      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          count_reg <= mpms_pkg::ONESHOT_ZERO;
        end
        else if (trigger)
        begin
          count_reg <= ONESHOT_CYCLES;
        end
        else if (mode_of(env2_config_reg, s) != mpms_pkg::MODE_SIG_B)
        begin
          count_reg <= mpms_pkg::ONESHOT_ZERO;
        end
        else if (count_reg != mpms_pkg::ONESHOT_ZERO)
        begin
          count_reg <= count_reg - mpms_pkg::ONESHOT_ONE;
        end
      end

      assign shot_active[s] = (count_reg != mpms_pkg::ONESHOT_ZERO);
    end
  endgenerate

  // ****************************************
  // terminal steering
  // ****************************************
  genvar p;
  generate
    for (p = 0; p < mpms_pkg::PIN_COUNT; p = p + 1)
    begin : g_pin
      logic [1:0] mode;

      assign mode = mode_of(env2_config_reg, p);

      if (p < mpms_pkg::SHOT_PINS)
      begin : g_phase
        // pins zero and one: motion phase or one-shot, polarity by bit
        always_comb
        begin
          pin_out_next[p]  = 1'b0;
          pin_oe_n_next[p] = 1'b0;
          case (mode)
            mpms_pkg::MODE_GP_IN:
            begin
              pin_oe_n_next[p] = 1'b1;
            end
            mpms_pkg::MODE_GP_OUT:
            begin
              pin_out_next[p] = gp_out_level_reg[p];
            end
            mpms_pkg::MODE_SIG_A:
            begin
              pin_out_next[p] = shot_pol_high[p] ? phase_sig[p] : !phase_sig[p];
            end
            default:
            begin
              pin_out_next[p] = shot_pol_high[p] ? shot_active[p] : !shot_active[p];
            end
          endcase
        end
      end
      else
      begin : g_match
        // pins two to seven: 10 active-low, 11 active-high
        always_comb
        begin
          pin_out_next[p]  = 1'b0;
          pin_oe_n_next[p] = 1'b0;
          case (mode)
            mpms_pkg::MODE_GP_IN:
            begin
              pin_oe_n_next[p] = 1'b1;
            end
            mpms_pkg::MODE_GP_OUT:
            begin
              pin_out_next[p] = gp_out_level_reg[p];
            end
            mpms_pkg::MODE_SIG_A:
            begin
              pin_out_next[p] = !phase_sig[p];
            end
            default:
            begin
              pin_out_next[p] = phase_sig[p];
            end
          endcase
        end
      end
    end
  endgenerate

  // ****************************************
  // pin registers
  // ****************************************
  // registered so the pads see no decode glitches; costs one cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_out_reg  <= '0;
      pin_oe_n_reg <= '1;
    end
    else
    begin
      pin_out_reg  <= pin_out_next;
      pin_oe_n_reg <= pin_oe_n_next;
    end
  end

  assign pin_out  = pin_out_reg;
  assign pin_oe_n = pin_oe_n_reg;

  // signal-mode check kept for readers of the one-shot status
  logic unused_ok;
  assign unused_ok = is_signal_mode(mode_of(env2_config_reg, 0)) | (|hsize);

endmodule

`default_nettype wire

// File: test/mpms_ext_io.sv
/*
  far-side machine lines for the pin mode block.
  assumes the bench sets ext_level, the level the far side holds.
*/
`timescale 1ns/10ps
`default_nettype none
module mpms_ext_io
(
  input  wire logic [mpms_pkg::PIN_COUNT-1:0] pin_out,
  input  wire logic [mpms_pkg::PIN_COUNT-1:0] pin_oe_n,
  input  wire logic [mpms_pkg::PIN_COUNT-1:0] ext_level,
  output logic [mpms_pkg::PIN_COUNT-1:0]      pin_in
);
  // driving terminal wins; a released one shows the far side
  assign pin_in = (pin_out & ~pin_oe_n) | (ext_level & pin_oe_n);
endmodule
`default_nettype wire

// File: test/mpms_checker.sv
/*
  assertions on the pin mode block, snooping config writes.
  assumes it is bound into mpms_top and sees only its ports.
*/
`timescale 1ns/10ps
`default_nettype none
module mpms_checker
#(
  parameter logic [mpms_pkg::ONESHOT_W-1:0] ONESHOT_CYCLES = mpms_pkg::ONESHOT_CYCLES_DFLT
)
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        accel_phase_flag,
  input wire logic        decel_phase_flag,
  input wire logic        constant_speed_flag,
  input wire logic        compare_one_match,
  input wire logic        compare_two_match,
  input wire logic        compare_three_match,
  input wire logic        compare_four_match,
  input wire logic        compare_five_match,
  input wire logic [7:0]  pin_out,
  input wire logic [7:0]  pin_oe_n
);
  logic [31:0] cfg, cfg_q;
  logic [7:0]  gp, gp_q, wa, in_m, out_m, sig_m, pol_v, src;
  logic        wr_p, shot_act;
  logic [18:0] run;
  assign src = {compare_five_match, compare_four_match, compare_three_match,
                compare_two_match, compare_one_match, constant_speed_flag,
                decel_phase_flag, accel_phase_flag};
  assign shot_act = (cfg_q[1:0] == mpms_pkg::MODE_SIG_B) && (pin_out[0] == cfg_q[16]);
  // ****************************************
  // shadow of the config and level writes
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      {wr_p, wa, cfg, cfg_q, gp, gp_q, run} <= '0;
    end
    else
    begin
      wr_p <= hsel && hready && htrans[1] && hwrite;
      wa <= haddr;
      if (wr_p && wa == mpms_pkg::OFF_ENV2_CONFIG)
        cfg <= hwdata;
      if (wr_p && wa == mpms_pkg::OFF_GP_OUT_LEVEL)
        gp <= hwdata[7:0];
      cfg_q <= cfg;
      gp_q <= gp;
      run <= shot_act ? run + 19'h0_0001 : 19'h0_0000;
    end
  end
  always_comb
  begin
    sig_m = 8'h00;
    pol_v = 8'h00;
    for (int k = 0; k < 8; k++)
    begin
      in_m[k] = cfg_q[2*k +: 2] == mpms_pkg::MODE_GP_IN;
      out_m[k] = cfg_q[2*k +: 2] == mpms_pkg::MODE_GP_OUT;
      pol_v[k] = cfg_q[2*k];
      if (k > 2)
        sig_m[k] = cfg_q[2*k+1];
    end
  end
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_reset; $rose(hresetn) |-> pin_oe_n == 8'hFF; endproperty
  a_reset: assert property (p_reset) else $error("pins not inputs after reset");
  property p_in; (in_m & ~pin_oe_n) == 8'h00; endproperty
  a_in: assert property (p_in) else $error("input pin driven");
  property p_out; (out_m & (pin_oe_n | (pin_out ^ gp_q))) == 8'h00; endproperty
  a_out: assert property (p_out) else $error("output pin level wrong");
  property p_accel; cfg_q[1:0] == mpms_pkg::MODE_SIG_A |-> !pin_oe_n[0]
    && pin_out[0] == ($past(accel_phase_flag) ~^ cfg_q[16]); endproperty
  a_accel: assert property (p_accel) else $error("accel pin wrong");
  property p_decel; cfg_q[3:2] == mpms_pkg::MODE_SIG_A |-> !pin_oe_n[1]
    && pin_out[1] == ($past(decel_phase_flag) ~^ cfg_q[17]); endproperty
  a_decel: assert property (p_decel) else $error("decel pin wrong");
  property p_speed; cfg_q[5] |-> !pin_oe_n[2]
    && pin_out[2] == ($past(constant_speed_flag) ~^ cfg_q[4]); endproperty
  a_speed: assert property (p_speed) else $error("speed pin wrong");
  property p_cmp; (sig_m & (pin_oe_n | (pin_out ^ ($past(src) ~^ pol_v)))) == 8'h00; endproperty
  a_cmp: assert property (p_cmp) else $error("compare pin wrong");
  property p_shot; $fell(shot_act) && cfg_q[1:0] == mpms_pkg::MODE_SIG_B
    |-> run == ONESHOT_CYCLES; endproperty
  a_shot: assert property (p_shot) else $error("one-shot width wrong");
  property p_shot_max; shot_act |-> run < ONESHOT_CYCLES; endproperty
  a_shot_max: assert property (p_shot_max) else $error("one-shot too long");
endmodule
bind mpms_top mpms_checker #(.ONESHOT_CYCLES(ONESHOT_CYCLES)) u_mpms_checker (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .accel_phase_flag(accel_phase_flag),
  .decel_phase_flag(decel_phase_flag), .constant_speed_flag(constant_speed_flag),
  .compare_one_match(compare_one_match), .compare_two_match(compare_two_match),
  .compare_three_match(compare_three_match), .compare_four_match(compare_four_match),
  .compare_five_match(compare_five_match), .pin_out(pin_out), .pin_oe_n(pin_oe_n));
`default_nettype wire

// File: test/tb_multipurpose_pin_mode_select.sv
/*
  self-checking bench for mpms_top over AHB-Lite.
  assumes mpms_pkg, the far-side model and the bound checker.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module tb_multipurpose_pin_mode_select;
  localparam logic [18:0] SHOT = 19'h0_0014;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [7:0]  haddr, flg, pin_in, pin_out, pin_oe_n, ext_level;
  logic [1:0]  htrans;
  logic [31:0] hwdata, hrdata;
  int          num_errors = 0;
  int          comparisons = 0;
  assign hready = hreadyout;
  mpms_top #(.ONESHOT_CYCLES(SHOT)) u_mpms_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .accel_phase_flag(flg[0]), .decel_phase_flag(flg[1]), .constant_speed_flag(flg[2]),
    .compare_one_match(flg[3]), .compare_two_match(flg[4]), .compare_three_match(flg[5]),
    .compare_four_match(flg[6]), .compare_five_match(flg[7]),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n));
  mpms_ext_io u_mpms_ext_io (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .ext_level(ext_level), .pin_in(pin_in));
  // ****************************************
  // bus tasks
  // ****************************************
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= mpms_pkg::HTRANS_NONSEQ_BIT;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
    `CHK("hresp", mpms_pkg::HRESP_OKAY, hresp)
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(a, 1'b1, d, r);
  endtask
  task automatic chk_rd(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(a, 1'b0, 32'h0000_0000, r);
    `CHK(n, e, r)
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    `CHK("reset oe_n", 8'hFF, pin_oe_n)
    `CHK("reset out", 8'h00, pin_out)
    chk_rd("reset cfg", mpms_pkg::OFF_ENV2_CONFIG, 32'h0000_0000);
    chk_rd("unmapped", 8'h40, 32'h0000_0000);
  endtask
  task automatic t_gpio();
    wr(mpms_pkg::OFF_ENV2_CONFIG, 32'h0000_5555);
    wr(mpms_pkg::OFF_GP_OUT_LEVEL, 32'h0000_00A5);
    repeat (2) @(posedge hclk);
    `CHK("gp out", 8'hA5, pin_out)
    `CHK("gp oe_n", 8'h00, pin_oe_n)
    chk_rd("cfg back", mpms_pkg::OFF_ENV2_CONFIG, 32'h0000_5555);
    chk_rd("gp back", mpms_pkg::OFF_GP_OUT_LEVEL, 32'h0000_00A5);
    wr(mpms_pkg::OFF_ENV2_CONFIG, 32'h0000_0000);
    ext_level <= 8'h3C;
    repeat (3) @(posedge hclk);
    `CHK("float", 8'hFF, pin_oe_n)
    chk_rd("gp in", mpms_pkg::OFF_GP_IN_LEVEL, 32'h0000_003C);
  endtask
  task automatic t_flags();
    logic [31:0] c;
    logic [7:0]  e;
    for (int i = 0; i < 8; i++)
    begin
      c = 32'h0000_000A | (i[0] ? 32'h0003_0000 : 32'h0000_0000);
      for (int k = 2; k < 8; k++)
        c[2*k +: 2] = i[1] ? mpms_pkg::MODE_SIG_B : mpms_pkg::MODE_SIG_A;
      flg <= i[2] ? 8'h96 : 8'h69;
      wr(mpms_pkg::OFF_ENV2_CONFIG, c);
      repeat (2) @(posedge hclk);
      e = flg ^ {{6{!i[1]}}, {2{!i[0]}}};
      `CHK("flag pins", e, pin_out)
      `CHK("flag oe_n", 8'h00, pin_oe_n)
    end
  endtask
  task automatic t_shot();
    int n;
    n = 0;
    wr(mpms_pkg::OFF_ENV2_CONFIG, 32'h0001_000F);
    wr(mpms_pkg::OFF_ONESHOT, 32'h0000_0003);
    repeat (4 * SHOT)
    begin
      @(posedge hclk);
      n += (pin_out[0] === 1'b1) && (pin_out[1] === 1'b0);
    end
    `CHK("shot len", SHOT, n[18:0])
    `CHK("shot idle", 8'h02, pin_out)
    chk_rd("shot done", mpms_pkg::OFF_ONESHOT, 32'h0000_0000);
  endtask
  task automatic t_rereset();
    wr(mpms_pkg::OFF_ENV2_CONFIG, 32'h0000_5555);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
  endtask
  task automatic conclude();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ****************************************
  // clock, sequence, watchdog
  // ****************************************
  initial
  begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  initial
  begin
    {hresetn, hsel, hwrite, haddr, htrans, hwdata, flg, ext_level} = '0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_gpio();
    t_flags();
    t_shot();
    t_rereset();
    conclude();
  end
  // whole run is under two hundred cycles; this leaves wide margin
  initial
  begin
    repeat (20000) @(posedge hclk);
    num_errors++;
    conclude();
  end
endmodule
`default_nettype wire
